// *** src/usb_cfg_pkg.sv ***
// Constants for the USB host controller configuration command and status pair
package usb_cfg_pkg;

  localparam logic [7:0]  CMD_IDX       = 8'h04;
  localparam logic [7:0]  STS_IDX       = 8'h06;

  localparam int          CMD_IO_BIT    = 0;
  localparam int          CMD_MEM_BIT   = 1;
  localparam int          CMD_BM_BIT    = 2;
  localparam int          CMD_MWI_BIT   = 4;
  localparam int          CMD_SERR_BIT  = 8;
  localparam int          CMD_FBB_BIT   = 9;

  // Only these command bits hold state; all others are wired to zero
  localparam logic [15:0] CMD_RW_MASK   = 16'h0317;
  localparam logic [15:0] CMD_RESET     = 16'h0000;

  // Error flags live in status bits 15:11, stored as a 5-bit field
  localparam int          STS_ERR_LSB   = 11;
  localparam int          ERR_TA_SIG    = 0;
  localparam int          ERR_TA_RCV    = 1;
  localparam int          ERR_MABORT    = 2;
  localparam int          ERR_SERR      = 3;
  localparam int          ERR_PERR      = 4;
  localparam logic [4:0]  STS_ERR_RESET = 5'h00;

  localparam logic [1:0]  DEVSEL_MEDIUM = 2'h1;
  localparam logic        FBB_CAPABLE   = 1'h1;

endpackage : usb_cfg_pkg

// *** src/usb_cfg_cmd_status.sv ***
// Configuration command and status registers of the USB host controller function
`timescale 1ns/1ps

module usb_cfg_cmd_status
  import usb_cfg_pkg::*;
(
  input  wire logic        clk_sys,         // System clock, 100 MHz
  input  wire logic        rst,             // Asynchronous reset, active high
  input  wire logic        cfg_wr,          // Configuration write strobe
  input  wire logic        cfg_rd,          // Configuration read strobe
  input  wire logic [7:0]  cfg_addr,        // Configuration index
  input  wire logic [1:0]  cfg_be,          // Byte enables for the 16-bit word
  input  wire logic [15:0] cfg_wdata,       // Write data
  output logic      [15:0] cfg_rdata,       // Read data, one cycle after cfg_rd
  output logic             cfg_rack,        // Read data valid pulse
  input  wire logic        ev_perr,         // Any parity error detected, pulse
  input  wire logic        ev_addr_perr,    // Address-phase parity error, pulse
  input  wire logic        ev_master_abort, // Own transaction master-aborted, pulse
  input  wire logic        ev_ta_rcvd,      // Own transaction target-aborted, pulse
  input  wire logic        ev_ta_sig,       // Target abort signalled by us, pulse
  input  wire logic        init_req,        // Engine wants to start a transaction
  output logic             init_go,         // Transaction start allowed
  input  wire logic        mem_hit,         // Memory-space decode hit
  output logic             mem_claim,       // Memory access accepted
  input  wire logic        io_hit,          // I/O-space decode hit
  output logic             io_claim,        // I/O access accepted
  output logic             bus_master_en,   // Command bus master enable
  output logic             mem_en,          // Command memory enable
  output logic             io_en,           // Command I/O enable
  output logic             mwi_en,          // Command write-and-invalidate enable
  output logic             serr_en,         // Command system-error report enable
  output logic             fbb_en           // Command fast back-to-back enable
);

  logic [15:0] cmd_q;
  logic [15:0] cmd_d;
  logic [4:0]  err_q;
  logic [4:0]  err_d;
  logic [4:0]  err_set;
  logic [15:0] sts_view;
  logic [15:0] rdata_q;
  logic        rack_q;
  logic        cmd_wr;
  logic        sts_wr;

  // Expands the two byte enables into a 16-bit write mask
  function automatic logic [15:0] lane_mask(input logic [1:0] be);
    lane_mask = {{8{be[1]}}, {8{be[0]}}};
  endfunction : lane_mask

  assign cmd_wr = cfg_wr && (cfg_addr == CMD_IDX);
  assign sts_wr = cfg_wr && (cfg_addr == STS_IDX);

  // Command register: only the implemented enables keep state
  always_comb begin
    cmd_d = cmd_q;
    if (cmd_wr) begin
      cmd_d = (cmd_q & ~lane_mask(cfg_be)) | (cfg_wdata & lane_mask(cfg_be));
    end
    cmd_d = cmd_d & CMD_RW_MASK;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cmd_q <= CMD_RESET;
    end else begin
      cmd_q <= cmd_d;
    end
  end

  assign bus_master_en = cmd_q[CMD_BM_BIT];
  assign mem_en        = cmd_q[CMD_MEM_BIT];
  assign io_en         = cmd_q[CMD_IO_BIT];
  assign mwi_en        = cmd_q[CMD_MWI_BIT];
  assign serr_en       = cmd_q[CMD_SERR_BIT];
  // Software is expected to set this; the engine issues back-to-back anyway
  assign fbb_en        = cmd_q[CMD_FBB_BIT];

  // Gating is combinational so a cleared enable stops the very next request
  assign init_go   = init_req && bus_master_en;
  assign mem_claim = mem_hit && mem_en;
  assign io_claim  = io_hit && io_en;

  // Error flags: a new event in the same cycle as a clearing write wins
  always_comb begin
    err_set              = 5'h00;
    err_set[ERR_PERR]    = ev_perr || ev_addr_perr;
    err_set[ERR_SERR]    = ev_addr_perr;
    err_set[ERR_MABORT]  = ev_master_abort;
    err_set[ERR_TA_RCV]  = ev_ta_rcvd;
    err_set[ERR_TA_SIG]  = ev_ta_sig;
    err_d = err_q;
    if (sts_wr && cfg_be[1]) begin
      err_d = err_q & ~cfg_wdata[15:STS_ERR_LSB];
    end
    err_d = err_d | err_set;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      err_q <= STS_ERR_RESET;
    end else begin
      err_q <= err_d;
    end
  end

  // Fixed fields: timing code, capability bit, zero for unsupported bits
  assign sts_view = {err_q, DEVSEL_MEDIUM, 1'b0, FBB_CAPABLE, 7'h00};

  // Read port; unmapped indexes answer zero so the bridge never sees X
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rdata_q <= 16'h0000;
    end else if (cfg_rd) begin
      if (cfg_addr == CMD_IDX) begin
        rdata_q <= cmd_q;
      end else if (cfg_addr == STS_IDX) begin
        rdata_q <= sts_view;
      end else begin
        rdata_q <= 16'h0000;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      rack_q <= 1'b0;
    end else begin
      rack_q <= cfg_rd;
    end
  end

  assign cfg_rdata = rdata_q;
  assign cfg_rack  = rack_q;

  sequence cmd_wr_hi_s;
    cfg_wr && (cfg_addr == CMD_IDX) && cfg_be[1];
  endsequence

  sequence cmd_wr_lo_s;
    cfg_wr && (cfg_addr == CMD_IDX) && cfg_be[0];
  endsequence

  sequence sts_rd_s;
    cfg_rd && (cfg_addr == STS_IDX);
  endsequence

  sequence cmd_rd_s;
    cfg_rd && (cfg_addr == CMD_IDX);
  endsequence

  sequence sts_clr_hi_s;
    cfg_wr && (cfg_addr == STS_IDX) && cfg_be[1];
  endsequence

  serr_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    cmd_wr_hi_s |=> (serr_en == $past(cfg_wdata[CMD_SERR_BIT])))
    else $error("serr enable did not follow write");

  hardwired_cmd_a: assert property (@(posedge clk_sys) disable iff (rst)
    cmd_rd_s |=> (cfg_rdata[7] == 1'b0) && (cfg_rdata[5] == 1'b0) && (cfg_rdata[3] == 1'b0))
    else $error("hardwired command bit read as one");

  perr_resp_a: assert property (@(posedge clk_sys) disable iff (rst)
    cmd_rd_s |=> (cfg_rdata[6] == 1'b0))
    else $error("parity response bit read as one");

  mwi_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    cmd_wr_lo_s |=> (mwi_en == $past(cfg_wdata[CMD_MWI_BIT])))
    else $error("write-invalidate enable did not follow write");

  master_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
    init_go |-> (init_req && cmd_q[CMD_BM_BIT]))
    else $error("transaction started without bus master enable");

  mem_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
    (mem_hit && !cmd_q[CMD_MEM_BIT]) |-> !mem_claim)
    else $error("memory access claimed while disabled");

  io_gate_a: assert property (@(posedge clk_sys) disable iff (rst)
    (io_hit && !cmd_q[CMD_IO_BIT]) |-> !io_claim)
    else $error("I/O access claimed while disabled");

  perr_flag_a: assert property (@(posedge clk_sys) disable iff (rst)
    ev_perr |=> err_q[ERR_PERR] ##1 sts_rd_s |=> cfg_rdata[15])
    else $error("parity error not recorded");

  err_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    (sts_wr && cfg_be[1] && cfg_wdata[15] && !ev_perr && !ev_addr_perr)
      |=> !err_q[ERR_PERR])
    else $error("written one did not clear parity flag");

  err_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    (sts_wr && !cfg_wdata[15] && err_q[ERR_PERR]) |=> err_q[ERR_PERR])
    else $error("written zero disturbed parity flag");

  serr_flag_a: assert property (@(posedge clk_sys) disable iff (rst)
    ev_addr_perr |=> err_q[ERR_SERR] && err_q[ERR_PERR])
    else $error("address parity error not recorded");

  mabort_flag_a: assert property (@(posedge clk_sys) disable iff (rst)
    ev_master_abort |=> err_q[ERR_MABORT])
    else $error("master abort not recorded");

  ta_rcvd_flag_a: assert property (@(posedge clk_sys) disable iff (rst)
    ev_ta_rcvd |=> err_q[ERR_TA_RCV])
    else $error("received target abort not recorded");

  ta_sig_flag_a: assert property (@(posedge clk_sys) disable iff (rst)
    ev_ta_sig |=> err_q[ERR_TA_SIG])
    else $error("signalled target abort not recorded");

  devsel_code_a: assert property (@(posedge clk_sys) disable iff (rst)
    sts_rd_s |=> (cfg_rdata[10:9] == 2'h1) && cfg_rack)
    else $error("timing code not medium");

  fixed_bits_a: assert property (@(posedge clk_sys) disable iff (rst)
    sts_rd_s |=> (cfg_rdata[8] == 1'b0) && (cfg_rdata[7] == 1'b1))
    else $error("fixed status bits wrong");

  reserved_zero_a: assert property (@(posedge clk_sys) disable iff (rst)
    sts_rd_s |=> (cfg_rdata[6:0] == 7'h00))
    else $error("reserved status bits not zero");

  bm_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    cmd_wr_lo_s |=> (bus_master_en == $past(cfg_wdata[CMD_BM_BIT])))
    else $error("bus master enable did not follow write");

  mem_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    cmd_wr_lo_s |=> (mem_en == $past(cfg_wdata[CMD_MEM_BIT])))
    else $error("memory enable did not follow write");

  io_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    cmd_wr_lo_s |=> (io_en == $past(cfg_wdata[CMD_IO_BIT])))
    else $error("I/O enable did not follow write");

  fbb_write_a: assert property (@(posedge clk_sys) disable iff (rst)
    cmd_wr_hi_s |=> (fbb_en == $past(cfg_wdata[CMD_FBB_BIT])))
    else $error("fast back-to-back enable did not follow write");

  cmd_hold_a: assert property (@(posedge clk_sys) disable iff (rst)
    !(cfg_wr && (cfg_addr == CMD_IDX)) |=> $stable(cmd_q))
    else $error("command changed without a write");

  cmd_reserved_a: assert property (@(posedge clk_sys) disable iff (rst)
    cmd_rd_s |=> (cfg_rdata[15:10] == 6'h00))
    else $error("reserved command bits not zero");

  cmd_readback_a: assert property (@(posedge clk_sys) disable iff (rst)
    cmd_rd_s |=> (cfg_rdata == $past(cmd_q)) && cfg_rack)
    else $error("command read data wrong");

  sts_readback_a: assert property (@(posedge clk_sys) disable iff (rst)
    sts_rd_s |=> (cfg_rdata[15:11] == $past(err_q)))
    else $error("status error flags read wrong");

  unmapped_rd_a: assert property (@(posedge clk_sys) disable iff (rst)
    (cfg_rd && (cfg_addr != CMD_IDX) && (cfg_addr != STS_IDX)) |=> (cfg_rdata == 16'h0000))
    else $error("unmapped index read not zero");

  perr_sticky_a: assert property (@(posedge clk_sys) disable iff (rst)
    (err_q[ERR_PERR] && !(sts_wr && cfg_be[1] && cfg_wdata[15])) |=> err_q[ERR_PERR])
    else $error("parity flag dropped without clear");

  serr_sticky_a: assert property (@(posedge clk_sys) disable iff (rst)
    (err_q[ERR_SERR] && !(sts_wr && cfg_be[1] && cfg_wdata[14])) |=> err_q[ERR_SERR])
    else $error("system error flag dropped without clear");

  mabort_sticky_a: assert property (@(posedge clk_sys) disable iff (rst)
    (err_q[ERR_MABORT] && !(sts_wr && cfg_be[1] && cfg_wdata[13])) |=> err_q[ERR_MABORT])
    else $error("master abort flag dropped without clear");

  ta_rcvd_sticky_a: assert property (@(posedge clk_sys) disable iff (rst)
    (err_q[ERR_TA_RCV] && !(sts_wr && cfg_be[1] && cfg_wdata[12])) |=> err_q[ERR_TA_RCV])
    else $error("received abort flag dropped without clear");

  ta_sig_sticky_a: assert property (@(posedge clk_sys) disable iff (rst)
    (err_q[ERR_TA_SIG] && !(sts_wr && cfg_be[1] && cfg_wdata[11])) |=> err_q[ERR_TA_SIG])
    else $error("signalled abort flag dropped without clear");

  serr_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    sts_clr_hi_s ##0 (cfg_wdata[14] && !ev_addr_perr) |=> !err_q[ERR_SERR])
    else $error("written one did not clear system error flag");

  mabort_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    sts_clr_hi_s ##0 (cfg_wdata[13] && !ev_master_abort) |=> !err_q[ERR_MABORT])
    else $error("written one did not clear master abort flag");

  ta_rcvd_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    sts_clr_hi_s ##0 (cfg_wdata[12] && !ev_ta_rcvd) |=> !err_q[ERR_TA_RCV])
    else $error("written one did not clear received abort flag");

  ta_sig_clear_a: assert property (@(posedge clk_sys) disable iff (rst)
    sts_clr_hi_s ##0 (cfg_wdata[11] && !ev_ta_sig) |=> !err_q[ERR_TA_SIG])
    else $error("written one did not clear signalled abort flag");

  mabort_quiet_a: assert property (@(posedge clk_sys) disable iff (rst)
    (!err_q[ERR_MABORT] && !ev_master_abort) |=> !err_q[ERR_MABORT])
    else $error("master abort flag set without event");

  master_open_a: assert property (@(posedge clk_sys) disable iff (rst)
    (init_req && cmd_q[CMD_BM_BIT]) |-> init_go)
    else $error("enabled transaction start was held back");

  mem_open_a: assert property (@(posedge clk_sys) disable iff (rst)
    (mem_hit && cmd_q[CMD_MEM_BIT]) |-> mem_claim)
    else $error("enabled memory access not claimed");

  io_open_a: assert property (@(posedge clk_sys) disable iff (rst)
    (io_hit && cmd_q[CMD_IO_BIT]) |-> io_claim)
    else $error("enabled I/O access not claimed");

endmodule : usb_cfg_cmd_status

// *** dv/cfg_host_model.sv ***
// Host bridge model issuing configuration reads and writes
`timescale 1ns/1ps
module cfg_host_model (
  input  wire logic        clk_sys,   // Clock
  output logic             cfg_wr,    // Write strobe
  output logic             cfg_rd,    // Read strobe
  output logic [7:0]       cfg_addr,  // Index
  output logic [1:0]       cfg_be,    // Byte enables
  output logic [15:0]      cfg_wdata, // Write data
  input  wire logic [15:0] cfg_rdata, // Read data
  input  wire logic        cfg_rack   // Read valid
);
  initial begin
    cfg_wr = 1'h0;
    cfg_rd = 1'h0;
    cfg_addr = 8'h00;
    cfg_be = 2'h0;
    cfg_wdata = 16'h0000;
  end
  // Index and data are inverted once released so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [1:0] be, input logic [15:0] d);
    @(posedge clk_sys);
    cfg_addr <= a;
    cfg_be <= be;
    cfg_wdata <= d;
    cfg_wr <= 1'h1;
    @(posedge clk_sys);
    cfg_wr <= 1'h0;
    cfg_addr <= ~a;
    cfg_wdata <= ~d;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [15:0] q, output logic ok);
    @(posedge clk_sys);
    cfg_addr <= a;
    cfg_rd <= 1'h1;
    @(posedge clk_sys);
    cfg_rd <= 1'h0;
    cfg_addr <= ~a;
    #1;
    ok = cfg_rack;
    q = cfg_rdata;
  endtask : rd
endmodule : cfg_host_model

// *** dv/usb_host_pci_cmd_status_tb_top.sv ***
// Testbench for the configuration command and status registers
`timescale 1ns/1ps
module usb_host_pci_cmd_status_tb_top;
  import usb_cfg_pkg::*;
  logic        clk_sys;
  logic        rst;
  logic        cfg_wr, cfg_rd, cfg_rack;
  logic [7:0]  cfg_addr;
  logic [1:0]  cfg_be;
  logic [15:0] cfg_wdata, cfg_rdata;
  logic [4:0]  ev;
  logic        init_req, mem_hit, io_hit, init_go, mem_claim, io_claim;
  logic [5:0]  en;
  int          fails, total_checks;

  cfg_host_model u_cfg_host_model (.clk_sys(clk_sys), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
    .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata),
    .cfg_rack(cfg_rack));
  usb_cfg_cmd_status u_usb_cfg_cmd_status (.clk_sys(clk_sys), .rst(rst), .cfg_wr(cfg_wr),
    .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_be(cfg_be), .cfg_wdata(cfg_wdata),
    .cfg_rdata(cfg_rdata), .cfg_rack(cfg_rack), .ev_perr(ev[ERR_PERR]),
    .ev_addr_perr(ev[ERR_SERR]), .ev_master_abort(ev[ERR_MABORT]),
    .ev_ta_rcvd(ev[ERR_TA_RCV]), .ev_ta_sig(ev[ERR_TA_SIG]), .init_req(init_req),
    .init_go(init_go), .mem_hit(mem_hit), .mem_claim(mem_claim), .io_hit(io_hit),
    .io_claim(io_claim), .bus_master_en(en[2]), .mem_en(en[1]), .io_en(en[0]),
    .mwi_en(en[3]), .serr_en(en[4]), .fbb_en(en[5]));

  initial begin
    clk_sys = 1'h0;
    forever #5 clk_sys = ~clk_sys;
  end

  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    total_checks++;
    if (g !== e) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask : chk

  task automatic rdchk(input string n, input logic [7:0] a, input logic [15:0] e);
    logic [15:0] q;
    logic        ok;
    u_cfg_host_model.rd(a, q, ok);
    chk({n, " ack"}, 16'h0001, {15'h0, ok});
    chk(n, e, q);
  endtask : rdchk

  task automatic t_reset();
    rdchk("cmd reset", CMD_IDX, 16'h0000);
    rdchk("sts reset", STS_IDX, 16'h0280);
    $display("test reset done");
  endtask : t_reset

  task automatic t_cmd();
    u_cfg_host_model.wr(CMD_IDX, 2'h3, 16'hffff);
    rdchk("cmd all ones", CMD_IDX, 16'h0317);
    chk("enables", 16'h003f, {10'h0, en});
    u_cfg_host_model.wr(CMD_IDX, 2'h1, 16'h0000);
    rdchk("cmd low lane", CMD_IDX, 16'h0300);
    u_cfg_host_model.wr(8'h08, 2'h3, 16'hffff);
    rdchk("unmapped", 8'h08, 16'h0000);
    u_cfg_host_model.wr(STS_IDX, 2'h3, 16'hffff);
    rdchk("sts read only", STS_IDX, 16'h0280);
    u_cfg_host_model.wr(CMD_IDX, 2'h2, 16'h0000);
    rdchk("cmd high lane", CMD_IDX, 16'h0000);
    $display("test command done");
  endtask : t_cmd

  task automatic t_gates();
    init_req <= 1'h1;
    mem_hit <= 1'h1;
    io_hit <= 1'h1;
    for (int i = 0; i < 8; i++) begin
      u_cfg_host_model.wr(CMD_IDX, 2'h3, 16'(i));
      #1;
      chk("gates", 16'(i), {13'h0, init_go, mem_claim, io_claim});
    end
    init_req <= 1'h0;
    mem_hit <= 1'h0;
    io_hit <= 1'h0;
    @(posedge clk_sys);
    #1;
    chk("gates idle", 16'h0000, {13'h0, init_go, mem_claim, io_claim});
    $display("test gates done");
  endtask : t_gates

  task automatic t_events();
    logic [15:0] e;
    for (int k = 0; k < 5; k++) begin
      // An address parity error is also a parity error, so it lands in two flags
      e = 16'h0280 | (16'h1 << (STS_ERR_LSB + k)) | ((k == ERR_SERR) ? 16'h8000 : 16'h0);
      @(posedge clk_sys);
      ev <= 5'(1 << k);
      @(posedge clk_sys);
      ev <= 5'h00;
      rdchk("sts event", STS_IDX, e);
      u_cfg_host_model.wr(STS_IDX, 2'h3, 16'h0000);
      rdchk("sts write zero", STS_IDX, e);
      u_cfg_host_model.wr(STS_IDX, 2'h1, 16'hffff);
      rdchk("sts low lane", STS_IDX, e);
      u_cfg_host_model.wr(STS_IDX, 2'h2, 16'hf800);
      rdchk("sts cleared", STS_IDX, 16'h0280);
    end
    $display("test events done");
  endtask : t_events

  task automatic t_collide();
    fork
      u_cfg_host_model.wr(STS_IDX, 2'h2, 16'h2000);
      begin
        @(posedge clk_sys);
        ev <= 5'(1 << ERR_MABORT);
        @(posedge clk_sys);
        ev <= 5'h00;
      end
    join
    rdchk("sts set wins", STS_IDX, 16'h2280);
    u_cfg_host_model.wr(STS_IDX, 2'h2, 16'h2000);
    rdchk("sts clear after", STS_IDX, 16'h0280);
    u_cfg_host_model.wr(CMD_IDX, 2'h3, 16'h0317);
    @(posedge clk_sys);
    ev <= 5'h1f;
    @(posedge clk_sys);
    ev <= 5'h00;
    rst <= 1'h1;
    repeat (2) @(posedge clk_sys);
    rst <= 1'h0;
    rdchk("cmd after reset", CMD_IDX, 16'h0000);
    rdchk("sts after reset", STS_IDX, 16'h0280);
    $display("test collide done");
  endtask : t_collide

  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : stop_test

  initial begin
    rst = 1'h1;
    ev = 5'h00;
    init_req = 1'h0;
    mem_hit = 1'h0;
    io_hit = 1'h0;
    fails = 0;
    total_checks = 0;
    repeat (6) @(posedge clk_sys);
    rst <= 1'h0;
    t_reset();
    t_cmd();
    t_gates();
    t_events();
    t_collide();
    stop_test();
  end

  // Whole run needs under two hundred cycles; ten thousand means a hang
  initial begin
    #100000;
    fails++;
    stop_test();
  end
endmodule : usb_host_pci_cmd_status_tb_top
